// [verilog/pmw_power_mode_wake.sv]
// Power-mode and wake controller: system clock select, sleep and idle modes,
// power-down and time-out flags, watchdog clear and wake sources.
// Assumes an AHB-Lite master, a CPU core on the same clock that honours the
// clock enable, and an analog fast oscillator whose ready level is async.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (R1) Select codes 0-6 pick fast clock divisions
// (R2) Leaving slow mode waits for fast stable
// (R3) Halt with both enables low: sleep
// (R4) Halt, fast off, sub on: sub idle
// (R5) Halt, both enables high: both-clock idle
// (R6) Halt, fast on, sub off: fast idle
// (R7) Low power keeps state, holds I/O
// (R8) Entry sets power-down, clears time-out
// (R9) Entry clears watchdog, counting continues
// (R10) Wake on pin fall, interrupt, watchdog
// (R11) Power-down clears only at power-up, clear
// (R12) Watchdog wake sets time-out, resets PC/SP
// (R13) Per-pin wake enable, resume after halt
// (R14) Unserviceable interrupt wake resumes after halt
// (R15) Serviceable interrupt wake responds at once
// (R16) Already-pending interrupt cannot wake
// (R17) Resume only after oscillator is stable
// (R18) Watchdog runs on slow oscillator/8
// (R19) Watchdog ratio 2^8..2^18 selectable
// (R20) Select code 7 picks sub clock
// (R21) Stable flag clears then sets on enable
// (R22) CPU clock released glitch-free after stable
module pmw_power_mode_wake import pmw_pkg::*; #(
	parameter int unsigned SLOW_DIV = SLOW_DIV_CYCLES,
	parameter int IRQ_N = IRQ_N_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic halt_in,
	input wire logic clr_wdt_in,
	input wire logic [IRQ_N-1:0] irq_req_in,
	input wire logic [IRQ_N-1:0] irq_en_in,
	input wire logic stack_full_in,
	input wire logic [PORT_A_W-1:0] port_a_in,
	input wire logic fast_osc_ready_in,
	output logic cpu_clk_en_out,
	output logic fast_clk_en_out,
	output logic sub_clk_en_out,
	output logic fast_osc_on_out,
	output logic io_hold_out,
	output logic wake_out,
	output logic irq_service_out,
	output logic pc_sp_reset_out,
	output logic wdt_reset_out,
	output logic power_down_flag_out,
	output logic timeout_flag_out
);
	pmw_wdt_if wdt_link ();

	logic [2:0] system_clock_select;
	logic fast_osc_idle_enable;
	logic low_osc_idle_enable;
	logic fosc_sw_en;
	logic [PORT_A_W-1:0] port_a_wake_enable;
	logic [2:0] watchdog_period_select;
	logic [2:0] active_sel;
	logic [2:0] next_active;
	pmw_state_t state;
	pmw_state_t next_state;
	pmw_lp_mode_t lp_mode;
	pmw_wake_t wake_cause;
	logic [IRQ_N-1:0] irq_pre;
	logic [IRQ_N-1:0] wake_irq;
	logic dp_valid;
	logic dp_write;
	logic [REG_AW-1:0] dp_addr;
	logic [SLOW_CNT_W-1:0] slow_cnt;
	logic [FAST_PRE_W-1:0] fast_pre;
	logic rdy_s1;
	logic rdy_s2;
	logic rdy_s3;
	logic rdy_filt;
	logic [SETTLE_W-1:0] settle;
	logic fast_osc_stable_flag;
	logic [PORT_A_W-1:0] pa_fall;

	// Bus decode.
	wire logic ap_take;
	wire logic [REG_AW-1:0] ap_addr;
	wire logic wr;
	wire logic wr_clk;
	wire logic wr_fosc;
	wire logic wr_wake;
	wire logic wr_wdt;
	wire logic [2:0] new_cks;
	wire logic [2:0] cks_now;
	wire logic [31:0] rd_word;

	assign ap_take = hsel_in && htrans_in[1] && hready_in;
	assign ap_addr = haddr_in[REG_AW-1:0];
	assign wr = dp_valid && dp_write;
	assign wr_clk = wr && (dp_addr == OFS_CLK_CTRL);
	assign wr_fosc = wr && (dp_addr == OFS_FOSC_CTRL);
	assign wr_wake = wr && (dp_addr == OFS_WAKE_EN);
	assign wr_wdt = wr && (dp_addr == OFS_WDT_CTRL);
	assign new_cks = hwdata_in[CKS_LSB +: 3];
	assign cks_now = wr_clk ? new_cks : system_clock_select;

	assign rd_word =
		(ap_addr == OFS_CLK_CTRL) ? 32'({system_clock_select, 3'h0,
			fast_osc_idle_enable, low_osc_idle_enable}) :
		(ap_addr == OFS_FOSC_CTRL) ? 32'({fast_osc_stable_flag,
			fosc_sw_en}) :
		(ap_addr == OFS_STATUS) ? 32'({2'(lp_mode), 2'h0, 2'(state),
			2'h0, timeout_flag_out, power_down_flag_out}) :
		(ap_addr == OFS_WAKE_EN) ? 32'(port_a_wake_enable) :
		(ap_addr == OFS_WDT_CTRL) ? 32'(watchdog_period_select) :
		(ap_addr == OFS_WDT_COUNT) ? 32'(wdt_link.count) :
		32'h0000_0000;

	// Clock and oscillator decode.
	wire logic active_fast;
	wire logic run_w;
	wire logic lowpwr_w;
	wire logic lp_fast;
	wire logic lp_sub;
	wire logic slow_tick;
	wire logic fast_tick;
	wire logic next_fosc_on;
	wire logic next_cpu_en;

	assign active_fast = (active_sel != CKS_SUB);
	assign run_w = (state == ST_RUN) || (state == ST_SWITCH);
	assign lowpwr_w = (state == ST_LOWPWR);
	assign lp_fast = (lp_mode == IDLE_BOTH_CLOCKS_MODE) ||
		(lp_mode == IDLE_FAST_CLOCK_MODE);
	assign lp_sub = (lp_mode == IDLE_BOTH_CLOCKS_MODE) ||
		(lp_mode == IDLE_SUB_CLOCK_MODE);
	assign slow_tick = (slow_cnt == SLOW_CNT_W'(SLOW_DIV - 1));
	assign fast_tick = ((fast_pre & div_mask(active_sel)) ==
		div_mask(active_sel)); // R1
	// In sleep the fast oscillator is off unless an idle mode keeps it.
	assign next_fosc_on = lowpwr_w ? lp_fast :
		(fosc_sw_en || active_fast || state == ST_SWITCH); // R3 R4 R6
	// The CPU only ever sees ticks of the running source; a change between fast codes
	// never gives a period shorter than the faster code's, but a change to or from the sub clock can.
	assign next_cpu_en = run_w && (active_fast ?
		(fast_tick && fast_osc_stable_flag) : slow_tick); // R22

	// Wake decode.
	wire logic halt_take;
	wire logic [IRQ_N-1:0] new_irq;
	wire logic pin_wake;
	wire logic wdt_ovf;
	wire logic wake_any;
	wire logic restart_done;
	wire logic resume;

	assign halt_take = (state == ST_RUN) && halt_in; // R3 R4 R5 R6
	assign new_irq = irq_req_in & ~irq_pre; // R16
	assign pin_wake = |(pa_fall & port_a_wake_enable); // R13
	assign wdt_ovf = wdt_link.overflow;
	assign wake_any = pin_wake || (|new_irq) || wdt_ovf; // R10
	assign restart_done = !active_fast || fast_osc_stable_flag; // R17
	assign resume = (state == ST_RESTART) && restart_done;

	assign wdt_link.tick = slow_tick;
	assign wdt_link.clear = halt_take || clr_wdt_in; // R9
	assign wdt_link.period_sel = watchdog_period_select; // R19

	pmw_watchdog u_wdt (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.wdt(wdt_link.wdt)
	);

	// Pin inputs idle high; a change counts once two stages agree.
	genvar gi;
	for (gi = 0; gi < PORT_A_W; gi++) begin : g_pin
		logic s1;
		logic s2;
		logic s3;
		logic filt;
		logic prev;
		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				{s1, s2, s3, filt, prev} <= 5'h1f;
			end else begin
				s1 <= port_a_in[gi];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3)
					filt <= s3;
				prev <= filt;
			end
		end
		assign pa_fall[gi] = prev && !filt;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			{rdy_s1, rdy_s2, rdy_s3, rdy_filt} <= 4'h0;
		end else begin
			rdy_s1 <= fast_osc_ready_in;
			rdy_s2 <= rdy_s1;
			rdy_s3 <= rdy_s2;
			if (rdy_s2 == rdy_s3)
				rdy_filt <= rdy_s3;
		end
	end

	// The settle count covers the synchroniser delay, so a ready level
	// left over from before the oscillator stopped is never trusted.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !fast_osc_on_out) begin
			settle <= '0;
			fast_osc_stable_flag <= 1'b0; // R21
		end else begin
			if (settle != SETTLE_W'(FOSC_SETTLE_CYCLES))
				settle <= settle + 1'b1;
			fast_osc_stable_flag <= rdy_filt &&
				(settle == SETTLE_W'(FOSC_SETTLE_CYCLES)); // R21
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || slow_tick)
			slow_cnt <= '0;
		else
			slow_cnt <= slow_cnt + 1'b1;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in)
			fast_pre <= '0;
		else
			fast_pre <= fast_pre + 1'b1;
	end

	always_comb begin
		next_state = state;
		next_active = active_sel;
		unique case (state)
			ST_RUN: begin
				if (halt_in) begin
					next_state = ST_LOWPWR;
				end else if (wr_clk) begin
					if (new_cks == CKS_SUB)
						next_active = CKS_SUB; // R20
					else if (fast_osc_stable_flag)
						next_active = new_cks; // R1
					else
						next_state = ST_SWITCH; // R2
				end
			end
			ST_SWITCH: begin
				if (cks_now == CKS_SUB) begin
					next_active = CKS_SUB; // R20
					next_state = ST_RUN;
				end else if (fast_osc_stable_flag) begin
					next_active = cks_now; // R2
					next_state = ST_RUN;
				end
			end
			ST_LOWPWR: begin
				if (wake_any)
					next_state = ST_RESTART; // R10
			end
			ST_RESTART: begin
				if (restart_done)
					next_state = ST_RUN; // R17
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state <= ST_RUN;
			active_sel <= CKS_RST;
			lp_mode <= MODE_SLEEP;
			irq_pre <= '0;
		end else begin
			state <= next_state;
			active_sel <= next_active;
			if (halt_take) begin
				lp_mode <= lp_mode_of(fast_osc_idle_enable,
					low_osc_idle_enable);
				irq_pre <= irq_req_in; // R16
			end
		end
	end

	// Watchdog has priority as the cause because it also rewinds the core.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wake_cause <= WAKE_PIN;
			wake_irq <= '0;
		end else if (lowpwr_w && wake_any) begin
			wake_cause <= wdt_ovf ? WAKE_WDT :
				(|new_irq) ? WAKE_IRQ : WAKE_PIN;
			wake_irq <= new_irq;
		end
	end

	// The core keeps the request pending itself; nothing here clears it.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wake_out <= 1'b0;
			irq_service_out <= 1'b0;
			pc_sp_reset_out <= 1'b0;
			wdt_reset_out <= 1'b0;
		end else begin
			wake_out <= resume; // R13 R14
			irq_service_out <= resume && wake_cause == WAKE_IRQ &&
				(|(wake_irq & irq_en_in)) && !stack_full_in; // R15
			pc_sp_reset_out <= resume && wake_cause == WAKE_WDT; // R12
			wdt_reset_out <= wdt_ovf && run_w;
		end
	end

	// Set wins over clear on both flags.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			power_down_flag_out <= 1'b0; // R11
			timeout_flag_out <= 1'b0;
		end else begin
			if (halt_take)
				power_down_flag_out <= 1'b1; // R8
			else if (clr_wdt_in)
				power_down_flag_out <= 1'b0; // R11
			if (wdt_ovf)
				timeout_flag_out <= 1'b1; // R12
			else if (halt_take)
				timeout_flag_out <= 1'b0; // R8
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cpu_clk_en_out <= 1'b0;
			fast_clk_en_out <= 1'b0;
			sub_clk_en_out <= 1'b0;
			fast_osc_on_out <= 1'b0;
			io_hold_out <= 1'b0;
		end else begin
			cpu_clk_en_out <= next_cpu_en; // R22
			fast_clk_en_out <= fast_osc_stable_flag &&
				(!lowpwr_w || lp_fast); // R5 R6
			sub_clk_en_out <= slow_tick && (!lowpwr_w || lp_sub); // R4 R5
			fast_osc_on_out <= next_fosc_on;
			io_hold_out <= (next_state == ST_LOWPWR) ||
				(next_state == ST_RESTART); // R7
		end
	end

	// Register contents survive every mode change; only rst_in resets them.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			system_clock_select <= CKS_RST;
			fast_osc_idle_enable <= 1'b0;
			low_osc_idle_enable <= 1'b0;
			fosc_sw_en <= 1'b0;
			port_a_wake_enable <= '0;
			watchdog_period_select <= WPS_RST;
		end else begin
			if (wr_clk) begin
				system_clock_select <= new_cks;
				fast_osc_idle_enable <= hwdata_in[FH_IDLE_BIT];
				low_osc_idle_enable <= hwdata_in[FS_IDLE_BIT];
			end
			if (wr_fosc)
				fosc_sw_en <= hwdata_in[FOSC_EN_BIT];
			if (wr_wake)
				port_a_wake_enable <= hwdata_in[PORT_A_W-1:0]; // R13
			if (wr_wdt)
				watchdog_period_select <= hwdata_in[2:0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= '0;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			dp_valid <= ap_take;
			dp_write <= hwrite_in;
			dp_addr <= ap_addr;
			if (ap_take && !hwrite_in)
				hrdata_out <= rd_word;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [shared/pmw_pkg.sv]
// Constants, register map, types and shared decoders of the power-mode and
// wake controller. Assumes a 20 MHz system clock and 32-bit register words.
package pmw_pkg;

	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SLOW_OSC_HZ = 32_768;
	// A tick period is a longest time, so the cycle count rounds down.
	localparam int unsigned SLOW_DIV_CYCLES = CLK_HZ / SLOW_OSC_HZ;
	localparam int SLOW_CNT_W = 12;
	localparam int unsigned WDT_PRE_DIV = 8;
	localparam int WDT_PRE_W = 3;
	localparam int WDT_CNT_W = 18;
	localparam int FAST_PRE_W = 6;
	localparam int PORT_A_W = 8;
	localparam int IRQ_N_DEF = 4;
	localparam int unsigned FOSC_SETTLE_CYCLES = 4;
	localparam int SETTLE_W = 3;
	localparam int REG_AW = 8;

	localparam logic [REG_AW-1:0] OFS_CLK_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] OFS_FOSC_CTRL = 8'h04;
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h08;
	localparam logic [REG_AW-1:0] OFS_WAKE_EN = 8'h0c;
	localparam logic [REG_AW-1:0] OFS_WDT_CTRL = 8'h10;
	localparam logic [REG_AW-1:0] OFS_WDT_COUNT = 8'h14;

	localparam int CKS_LSB = 5;
	localparam int FH_IDLE_BIT = 1;
	localparam int FS_IDLE_BIT = 0;
	localparam int FOSC_EN_BIT = 0;
	localparam int FOSC_STABLE_BIT = 1;
	localparam int STAT_PDF_BIT = 0;
	localparam int STAT_TO_BIT = 1;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_MODE_LSB = 8;

	localparam logic [2:0] CKS_SUB = 3'h7;
	localparam logic [2:0] CKS_RST = 3'h7;
	localparam logic [2:0] WPS_RST = 3'h3;

	typedef enum logic [1:0] {ST_RUN, ST_SWITCH, ST_LOWPWR, ST_RESTART}
		pmw_state_t;
	typedef enum logic [1:0] {
		MODE_SLEEP, IDLE_SUB_CLOCK_MODE, IDLE_BOTH_CLOCKS_MODE,
		IDLE_FAST_CLOCK_MODE
	} pmw_lp_mode_t;
	typedef enum logic [1:0] {WAKE_PIN, WAKE_IRQ, WAKE_WDT} pmw_wake_t;

	function automatic pmw_lp_mode_t lp_mode_of(input logic fh,
		input logic fs);
		if (!fh && !fs)
			return MODE_SLEEP;
		else if (!fh)
			return IDLE_SUB_CLOCK_MODE;
		else if (fs)
			return IDLE_BOTH_CLOCKS_MODE;
		else
			return IDLE_FAST_CLOCK_MODE;
	endfunction

	function automatic logic [FAST_PRE_W-1:0] div_mask(input logic [2:0] sel);
		return FAST_PRE_W'((7'h01 << sel) - 7'h01);
	endfunction

	function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [2:0] sel);
		case (sel)
			3'h0: return 18'h000ff;
			3'h1: return 18'h003ff;
			3'h2: return 18'h00fff;
			3'h3: return 18'h03fff;
			3'h4: return 18'h07fff;
			3'h5: return 18'h0ffff;
			3'h6: return 18'h1ffff;
			default: return 18'h3ffff;
		endcase
	endfunction

endpackage

// [shared/pmw_wdt_if.sv]
// Link between the mode controller and its watchdog counter.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface pmw_wdt_if import pmw_pkg::*; ();
	logic tick;
	logic clear;
	logic [2:0] period_sel;
	logic overflow;
	logic [WDT_CNT_W-1:0] count;
	modport ctrl(output tick, output clear, output period_sel,
		input overflow, input count);
	modport wdt(input tick, input clear, input period_sel,
		output overflow, output count);
endinterface
`default_nettype wire

// [verilog/pmw_watchdog.sv]
// Always-enabled watchdog counter on the slow oscillator tick.
// Assumes the tick is a one-cycle enable at the slow oscillator rate.
`timescale 1ns/10ps
`default_nettype none
module pmw_watchdog import pmw_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	pmw_wdt_if.wdt wdt
);
	logic [WDT_PRE_W-1:0] pre;
	logic [WDT_CNT_W-1:0] cnt;
	logic ovf;
	wire logic wdt_tick;
	wire logic at_limit;

	assign wdt_tick = wdt.tick && (pre == WDT_PRE_W'(WDT_PRE_DIV - 1)); // R18
	assign at_limit = (cnt == wdt_limit(wdt.period_sel)); // R19
	assign wdt.overflow = ovf;
	assign wdt.count = cnt;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || wdt.clear) begin
			pre <= '0;
			cnt <= '0;
			ovf <= 1'b0;
		end else begin
			if (wdt.tick)
				pre <= pre + 1'b1;
			if (wdt_tick)
				cnt <= at_limit ? '0 : cnt + 1'b1;
			ovf <= wdt_tick && at_limit;
		end
	end
endmodule
`default_nettype wire

// [bench/pmw_checker.sv]
// Port assertions for the power-mode and wake controller.
// Assumes it is bound to pmw_power_mode_wake.
`timescale 1ns/10ps
`default_nettype none
module pmw_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic clr_wdt_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic cpu_clk_en_out,
	input wire logic fast_clk_en_out,
	input wire logic fast_osc_on_out,
	input wire logic io_hold_out,
	input wire logic wake_out,
	input wire logic irq_service_out,
	input wire logic pc_sp_reset_out,
	input wire logic wdt_reset_out,
	input wire logic power_down_flag_out,
	input wire logic timeout_flag_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_bus_always_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer not ready or not okay");
	a_entry_sets_flags: assert property ($rose(io_hold_out) |->
		power_down_flag_out && !timeout_flag_out)
		else $error("flags wrong on low power entry");
	a_halted_cpu_quiet: assert property (
		io_hold_out && $past(io_hold_out) |-> !cpu_clk_en_out)
		else $error("cpu clock runs while halted");
	a_wake_single: assert property (wake_out |=> !wake_out)
		else $error("wake pulse too long");
	a_service_on_wake: assert property (irq_service_out |->
		wake_out && !pc_sp_reset_out)
		else $error("service pulse without wake");
	a_wdt_wake_to: assert property (pc_sp_reset_out |->
		wake_out && timeout_flag_out)
		else $error("watchdog wake without time-out flag");
	a_pdf_clear_cause: assert property ($fell(power_down_flag_out) |->
		$past(clr_wdt_in))
		else $error("power-down flag cleared without cause");
	a_to_brings_wake: assert property ($rose(timeout_flag_out) &&
		!wdt_reset_out && !$past(wdt_reset_out) |-> ##[1:80] pc_sp_reset_out)
		else $error("time-out without watchdog wake");
	a_fast_after_settle: assert property ($rose(fast_clk_en_out) |->
		fast_osc_on_out && $past(fast_osc_on_out, 4))
		else $error("fast clock enabled before settling");
	a_wake_after_hold: assert property (wake_out |-> !io_hold_out &&
		($past(io_hold_out) || $past(io_hold_out, 2)))
		else $error("wake not after restart");
endmodule
`default_nettype wire

// [bench/pmw_core_model.sv]
// Model of the CPU core, the port A pins and the fast oscillator.
// Assumes the bench steers it with plain levels on the system clock.
`timescale 1ns/10ps
`default_nettype none
module pmw_core_model (
	input wire logic clk_in,
	input wire logic cpu_clk_en_in,
	input wire logic halt_req_in,
	input wire logic [7:0] pin_low_in,
	input wire logic osc_on_in,
	input wire logic [7:0] osc_dly_in,
	output logic halt_out,
	output logic [7:0] port_a_out,
	output logic osc_ready_out
);
	logic [7:0] osc_cnt;
	// Pins have pull-ups, so a released pin reads high.
	assign port_a_out = ~pin_low_in;
	// The core runs its halt only on a clock-enabled cycle.
	always @(posedge clk_in) begin
		halt_out <= halt_req_in && cpu_clk_en_in && !halt_out;
		if (!osc_on_in)
			osc_cnt <= 8'h00;
		else if (osc_cnt < osc_dly_in)
			osc_cnt <= osc_cnt + 8'h01;
		osc_ready_out <= osc_on_in && osc_cnt >= osc_dly_in;
	end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the power-mode and wake controller.
// Assumes the checker and core model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pmw_pkg::*;
	localparam int SD = 2;
	logic clk_sys_in = 1'b0, rst_in = 1'b1, hwrite = 1'b0, rd_ph = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic halt_req = 1'b0, clr_wdt = 1'b0, stack_full = 1'b0;
	logic [3:0] irq_req = 4'h0, irq_en = 4'h0;
	logic [7:0] pin_low = 8'h00, osc_dly = 8'h01, port_a;
	logic halt, osc_rdy, hready, hresp, cpu_en, fast_en, sub_en, osc_on;
	logic io_hold, wake, svc, pcsp, wdtr, power_down_flag, tof;
	int bad_count = 0, n_checks = 0, seed = 54, cyc = 0, pin, p, s, t0;
	logic [31:0] exp_rd[$];
	logic [1:0] exp_wk[$];
	always #25 clk_sys_in = ~clk_sys_in;
	pmw_power_mode_wake #(.SLOW_DIV(SD)) dut (.clk_sys_in, .rst_in,
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .halt_in(halt), .clr_wdt_in(clr_wdt),
		.irq_req_in(irq_req), .irq_en_in(irq_en), .stack_full_in(stack_full),
		.port_a_in(port_a), .fast_osc_ready_in(osc_rdy),
		.cpu_clk_en_out(cpu_en), .fast_clk_en_out(fast_en),
		.sub_clk_en_out(sub_en), .fast_osc_on_out(osc_on),
		.io_hold_out(io_hold), .wake_out(wake), .irq_service_out(svc),
		.pc_sp_reset_out(pcsp), .wdt_reset_out(wdtr),
		.power_down_flag_out(power_down_flag), .timeout_flag_out(tof));
	pmw_core_model core (.clk_in(clk_sys_in), .cpu_clk_en_in(cpu_en),
		.halt_req_in(halt_req), .pin_low_in(pin_low), .osc_on_in(osc_on),
		.osc_dly_in(osc_dly), .halt_out(halt), .port_a_out(port_a),
		.osc_ready_out(osc_rdy));
	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Results are matched against notes in the order they were made.
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (rd_ph && hready)
			cmp(hrdata, exp_rd.size() ? exp_rd.pop_front() : 32'hdeadbeef);
		if (wake === 1'b1)
			cmp(32'({svc, pcsp}), exp_wk.size() ? exp_wk.pop_front() : 2'h3);
		if (cyc == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk_sys_in);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		rd_ph <= !w;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		xfer(a, 1'b0, 32'h0);
	endtask
	task automatic sleep_in();
		halt_req <= 1'b1;
		while (io_hold !== 1'b1) @(posedge clk_sys_in);
		halt_req <= 1'b0;
	endtask
	task automatic wait_run();
		while (wake !== 1'b1) @(posedge clk_sys_in);
	endtask
	task automatic period();
		p = 0;
		while (cpu_en !== 1'b1) @(posedge clk_sys_in);
		do begin
			@(posedge clk_sys_in);
			p++;
		end while (cpu_en !== 1'b1);
	endtask
	task automatic clear_wdt();
		clr_wdt <= 1'b1;
		@(posedge clk_sys_in);
		clr_wdt <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(8'h00, 32'he0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h10, 32'h3);
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'h0);
		wr(8'h04, 32'h1);
		repeat (20) @(posedge clk_sys_in);
		rd(8'h04, 32'h3);
		wr(8'h04, 32'h0);
		period();
		cmp(p, SD);
		for (int n = 0; n < 7; n++) begin
			// Odd codes see a slow oscillator, even ones a prompt one.
			osc_dly <= n[0] ? 8'h1e : 8'h01;
			wr(8'h00, 32'(n << 5));
			rd(8'h04, 32'h0);
			repeat (60) @(posedge clk_sys_in);
			rd(8'h04, 32'h2);
			period();
			cmp(p, 1 << n);
			cmp(fast_en, 1'b1);
			wr(8'h00, 32'he0);
		end
		for (int m = 0; m < 4; m++) begin
			pin = $unsigned($random(seed)) % 8;
			wr(8'h0c, 32'h1 << pin);
			wr(8'h00, 32'he0 | {m[1], m[0] ^ m[1]});
			sleep_in();
			rd(8'h08, 32'h21 | (m << 8));
			cmp(osc_on, m[1]);
			s = 0;
			repeat (8) @(posedge clk_sys_in) s += sub_en;
			cmp(s != 0, m == 1 || m == 2);
			pin_low <= 8'h1 << ((pin + 1) % 8);
			repeat (20) @(posedge clk_sys_in);
			cmp(io_hold, 1'b1);
			cmp(fast_en, m[1]);
			pin_low <= 8'h00;
			repeat (8) @(posedge clk_sys_in);
			exp_wk.push_back(2'h0);
			pin_low <= 8'h1 << pin;
			wait_run();
			pin_low <= 8'h00;
			rd(8'h00, 32'he0 | {m[1], m[0] ^ m[1]});
			rd(8'h08, 32'h1 | (m << 8));
			clear_wdt();
			rd(8'h08, 32'(m << 8));
		end
		irq_en <= 4'hb;
		irq_req <= 4'h1;
		for (int k = 1; k < 4; k++) begin
			stack_full <= (k == 3);
			sleep_in();
			repeat (20) @(posedge clk_sys_in);
			cmp(io_hold, 1'b1);
			exp_wk.push_back({k == 1, 1'b0});
			irq_req <= 4'h1 | (4'h1 << k);
			wait_run();
			irq_req <= 4'h1;
		end
		wr(8'h00, 32'he0);
		for (int w = 0; w < 2; w++) begin
			wr(8'h10, 32'(w));
			clear_wdt();
			rd(8'h14, 32'h0);
			// A halt that fails to clear the counter shortens the wait.
			repeat (2000) @(posedge clk_sys_in);
			exp_wk.push_back(2'h1);
			sleep_in();
			t0 = cyc;
			rd(8'h08, 32'h21);
			wait_run();
			s = (1 << (8 + 2 * w)) * 8 * SD;
			cmp(cyc - t0 >= s - 4 && cyc - t0 < s + 12, 1'b1);
			rd(8'h08, 32'h3);
		end
		// An overflow while running asks for a device reset instead.
		wr(8'h10, 32'h0);
		clear_wdt();
		t0 = cyc;
		s = (1 << 8) * 8 * SD;
		while (wdtr !== 1'b1) @(posedge clk_sys_in);
		cmp(cyc - t0 >= s - 4 && cyc - t0 < s + 12, 1'b1);
		cmp(pcsp, 1'b0);
		tally_and_finish();
	end
endmodule
bind pmw_power_mode_wake pmw_checker chk (.clk_sys_in, .rst_in,
	.clr_wdt_in, .hreadyout_out, .hresp_out, .cpu_clk_en_out,
	.fast_clk_en_out, .fast_osc_on_out, .io_hold_out, .wake_out,
	.irq_service_out, .pc_sp_reset_out, .wdt_reset_out,
	.power_down_flag_out, .timeout_flag_out);
`default_nettype wire
